// File: inc/twowire_irq_pkg.sv
// constants for the two-wire interface interrupt and reset block
// assumes a bus clock domain and a separate link clock domain
package twowire_irq_pkg;

  // ----------------------------------------------------------------
  // event sources
  // ----------------------------------------------------------------
  localparam int NUM_EVENTS = 3;
  localparam int EVT_BYTE_DONE = 0;
  localparam int EVT_ADDR_MATCH = 1;
  localparam int EVT_ARB_LOST = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic RST_FLAG = 1'h0;
  localparam logic RST_STATUS = 1'h0;
  localparam logic RST_IRQ = 1'h0;
  localparam logic RST_LINK_ACTIVE = 1'h0;
  localparam logic RST_SYNC = 1'h0;

  // ----------------------------------------------------------------
  // fixed outputs
  // ----------------------------------------------------------------
  localparam logic MCU_RESET_NONE = 1'h0;

endpackage

// File: src/event_toggle_sync.sv
// toggle crossing of a one-cycle event from a source to a destination clock
// assumes both resets are the same asynchronous active-low signal
`timescale 1ns/1ns
module event_toggle_sync
  import twowire_irq_pkg::*;
(
  // source side
  input wire logic src_clk,
  input wire logic src_pulse,
  // destination side
  input wire logic dst_clk,
  output logic dst_pulse,
  // reset
  input wire logic resetn
);

  // ----------------------------------------------------------------
  // source toggle
  // ----------------------------------------------------------------
  logic toggle_q;
  logic toggle_d;

  always_comb begin
    toggle_d = toggle_q ^ src_pulse;
  end

  always_ff @(posedge src_clk or negedge resetn) begin
    if (!resetn) begin
      toggle_q <= RST_SYNC;
    end else begin
      toggle_q <= toggle_d;
    end
  end

  // ----------------------------------------------------------------
  // destination stages
  // ----------------------------------------------------------------
  logic sync1_q, sync2_q, sync3_q, seen_q, pulse_q;
  logic seen_d, pulse_d;

  // change counts once stages two and three agree
  always_comb begin
    pulse_d = (sync2_q == sync3_q) && (sync3_q != seen_q);
    seen_d = pulse_d ? sync3_q : seen_q;
  end

  always_ff @(posedge dst_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= RST_SYNC;
      sync2_q <= RST_SYNC;
      sync3_q <= RST_SYNC;
      seen_q <= RST_SYNC;
      pulse_q <= RST_SYNC;
    end else begin
      sync1_q <= toggle_q;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      seen_q <= seen_d;
      pulse_q <= pulse_d;
    end
  end

  assign dst_pulse = pulse_q;

endmodule

// File: src/twowire_irq_and_reset.sv
// interrupt and reset logic of the two-wire serial interface
// assumes software bits arrive as ports on mclk, bus events on link_clk
`timescale 1ns/1ns
module twowire_irq_and_reset
  import twowire_irq_pkg::*;
(
  // bus clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // software control
  input wire logic two_wire_enable,
  input wire logic irq_enable_bit,
  input wire logic flag_write,
  input wire logic flag_wdata,
  // link domain events
  input wire logic link_clk,
  input wire logic byte_done_evt,
  input wire logic addr_match_evt,
  input wire logic arb_lost_evt,
  // link domain state
  output logic link_active,
  // status and interrupt
  output logic irq_pending_flag,
  output logic byte_done_status,
  output logic addressed_as_target_status,
  output logic arbitration_lost_status,
  output logic irq_req,
  // system reset request
  output logic mcu_reset_req
);

  // ----------------------------------------------------------------
  // enable into link domain
  // ----------------------------------------------------------------
  logic en_s1_q, en_s2_q, en_s3_q, link_active_q;
  logic link_active_d;

  always_comb begin
    link_active_d = (en_s2_q == en_s3_q) ? en_s3_q : link_active_q;
  end

  // disabled from reset until the enable has crossed
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      en_s1_q <= RST_SYNC;
      en_s2_q <= RST_SYNC;
      en_s3_q <= RST_SYNC;
      link_active_q <= RST_LINK_ACTIVE;
    end else begin
      en_s1_q <= two_wire_enable;
      en_s2_q <= en_s1_q;
      en_s3_q <= en_s2_q;
      link_active_q <= link_active_d;
    end
  end

  assign link_active = link_active_q;

  // ----------------------------------------------------------------
  // event crossing
  // ----------------------------------------------------------------
  logic [NUM_EVENTS-1:0] link_evt;
  logic [NUM_EVENTS-1:0] evt_pulse;
  logic [NUM_EVENTS-1:0] accept;

  assign link_evt[EVT_BYTE_DONE] = byte_done_evt;
  assign link_evt[EVT_ADDR_MATCH] = addr_match_evt;
  assign link_evt[EVT_ARB_LOST] = arb_lost_evt;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_evt
      event_toggle_sync u_sync (
        .src_clk(link_clk),
        .src_pulse(link_evt[gi] & link_active_q),
        .dst_clk(mclk),
        .dst_pulse(evt_pulse[gi]),
        .resetn(resetn)
      );
      assign accept[gi] = evt_pulse[gi] & two_wire_enable;
    end
  endgenerate

  // ----------------------------------------------------------------
  // flag, status and interrupt
  // ----------------------------------------------------------------
  logic pending_q, pending_d, irq_q, irq_d, clear_one;
  logic [NUM_EVENTS-1:0] status_q, status_d;

  always_comb begin
    clear_one = flag_write & flag_wdata;
    // set wins over clear; zero write keeps the flag
    pending_d = (|accept) | (pending_q & ~clear_one);
    status_d = accept | (status_q & {NUM_EVENTS{~clear_one}});
    irq_d = pending_d & irq_enable_bit;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pending_q <= RST_FLAG;
      status_q <= {NUM_EVENTS{RST_STATUS}};
      irq_q <= RST_IRQ;
    end else begin
      pending_q <= pending_d;
      status_q <= status_d;
      irq_q <= irq_d;
    end
  end

  assign irq_pending_flag = pending_q;
  assign byte_done_status = status_q[EVT_BYTE_DONE];
  assign addressed_as_target_status = status_q[EVT_ADDR_MATCH];
  assign arbitration_lost_status = status_q[EVT_ARB_LOST];
  assign irq_req = irq_q;
  assign mcu_reset_req = MCU_RESET_NONE;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_write_one;
    flag_write && flag_wdata && !(|accept);
  endsequence

  sequence s_hold_zero;
    pending_q && !(flag_write && flag_wdata);
  endsequence

  sequence s_event_seen;
    |accept;
  endsequence

  AST_NO_MCU_RESET: assert property (@(posedge mclk) disable iff (!resetn)
    mcu_reset_req == 1'h0)
    else $error("block requested a microcontroller reset");

  AST_IRQ_GATED: assert property (@(posedge mclk) disable iff (!resetn)
    irq_req == (irq_pending_flag && $past(irq_enable_bit)))
    else $error("irq not equal to pending flag and enable");

  AST_IRQ_HAS_SOURCE: assert property (@(posedge mclk) disable iff (!resetn)
    irq_req |-> (byte_done_status || addressed_as_target_status || arbitration_lost_status))
    else $error("irq raised with no status source");

  AST_EVENT_SETS_FLAG: assert property (@(posedge mclk) disable iff (!resetn)
    s_event_seen |=> irq_pending_flag)
    else $error("event did not set pending flag");

  AST_ARB_STATUS: assert property (@(posedge mclk) disable iff (!resetn)
    accept[EVT_ARB_LOST] |=> arbitration_lost_status ##0 irq_pending_flag)
    else $error("arbitration lost status not shown");

  AST_ADDR_STATUS: assert property (@(posedge mclk) disable iff (!resetn)
    accept[EVT_ADDR_MATCH] |=> addressed_as_target_status)
    else $error("address match status not shown");

  AST_ZERO_KEEPS: assert property (@(posedge mclk) disable iff (!resetn)
    s_hold_zero |=> irq_pending_flag)
    else $error("pending flag dropped without a one write");

  AST_ONE_CLEARS: assert property (@(posedge mclk) disable iff (!resetn)
    s_write_one |=> !irq_pending_flag ##0 !byte_done_status)
    else $error("one write did not clear the flag");

  AST_DISABLED_QUIET: assert property (@(posedge mclk) disable iff (!resetn)
    !two_wire_enable ##0 !irq_pending_flag |=> !irq_pending_flag)
    else $error("flag set while interface disabled");

  AST_LINK_FOLLOWS: assert property (@(posedge link_clk) disable iff (!resetn)
    $rose(link_active) |-> $past(en_s3_q) && $past(en_s2_q))
    else $error("link went active without a stable enable");

  sequence s_quiet_hold;
    s_hold_zero ##0 !(|accept);
  endsequence

  AST_BYTE_STATUS: assert property (@(posedge mclk) disable iff (!resetn)
    accept[EVT_BYTE_DONE] |=> byte_done_status)
    else $error("byte done status not shown");

  AST_STATUS_NEEDS_FLAG: assert property (@(posedge mclk) disable iff (!resetn)
    (byte_done_status || addressed_as_target_status || arbitration_lost_status) |-> irq_pending_flag)
    else $error("status bit set without pending flag");

  AST_FLAG_NEEDS_STATUS: assert property (@(posedge mclk) disable iff (!resetn)
    irq_pending_flag |-> (byte_done_status || addressed_as_target_status || arbitration_lost_status))
    else $error("pending flag set with no status bit");

  AST_FLAG_RISE_CAUSE: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(irq_pending_flag) |-> |$past(accept))
    else $error("pending flag rose without an event");

  AST_FLAG_FALL_CAUSE: assert property (@(posedge mclk) disable iff (!resetn)
    $fell(irq_pending_flag) |-> $past(clear_one))
    else $error("pending flag fell without a one write");

  AST_STATUS_KEEPS: assert property (@(posedge mclk) disable iff (!resetn)
    s_quiet_hold |=> $stable({byte_done_status, addressed_as_target_status, arbitration_lost_status}))
    else $error("status bits changed without event or clear");

  AST_CLEAR_DROPS_IRQ: assert property (@(posedge mclk) disable iff (!resetn)
    s_write_one |=> !irq_req)
    else $error("irq still raised after a one write");

  AST_IRQ_MASKED: assert property (@(posedge mclk) disable iff (!resetn)
    !irq_enable_bit |=> !irq_req)
    else $error("irq raised while interrupt enable low");

  AST_IRQ_ENABLED: assert property (@(posedge mclk) disable iff (!resetn)
    irq_enable_bit && s_hold_zero |=> irq_req)
    else $error("irq missing with flag and enable set");

  AST_LINK_OFF: assert property (@(posedge link_clk) disable iff (!resetn)
    !en_s2_q && !en_s3_q |=> !link_active)
    else $error("link active with enable low");

  AST_LINK_WAITS: assert property (@(posedge link_clk) disable iff (!resetn)
    (en_s2_q != en_s3_q) |=> $stable(link_active))
    else $error("link state changed before stages agreed");

endmodule

// File: testbench/link_event_source.sv
// far-side model: bus events of the two-wire link, one link_clk cycle each
// assumes a free-running link_clk and events requested by task call
`timescale 1ns/1ns
module link_event_source (
  // link clock
  input wire logic link_clk,
  // event pulses
  output logic byte_done_evt,
  output logic addr_match_evt,
  output logic arb_lost_evt
);
  logic [2:0] evt_q = 3'h0;

  assign {arb_lost_evt, addr_match_evt, byte_done_evt} = evt_q;

  // ----------------------------------------------------------------
  // one pulse after a whole nine-bit byte or arbitration step
  // ----------------------------------------------------------------
  task automatic send(input int idx);
    @(negedge link_clk);
    evt_q[idx] = 1'b1;
    @(negedge link_clk);
    evt_q = 3'h0;
  endtask
endmodule

// File: testbench/twowire_irq_and_reset_test.sv
// self-checking bench of the two-wire interrupt and reset block
// assumes the link event model drives the link side of the block
`timescale 1ns/1ns
module twowire_irq_and_reset_test
  import twowire_irq_pkg::*;
;
  logic mclk = 0, link_clk = 0, resetn = 0;
  logic two_wire_enable = 0, irq_enable_bit = 0, flag_write = 0, flag_wdata = 0;
  logic byte_done_evt, addr_match_evt, arb_lost_evt, link_active, irq_pending_flag, irq_req;
  logic byte_done_status, addressed_as_target_status, arbitration_lost_status, mcu_reset_req;
  int errors = 0, checked = 0, seed = 94;
  logic [4:0] exp_q[$];
  logic [4:0] prev_q = 5'h00;
  wire [4:0] seen = {irq_pending_flag, byte_done_status, addressed_as_target_status,
    arbitration_lost_status, irq_req};

  always #5 mclk = ~mclk;
  always #16 link_clk = ~link_clk;

  twowire_irq_and_reset u_twowire_irq_and_reset (.mclk(mclk), .resetn(resetn),
    .two_wire_enable(two_wire_enable), .irq_enable_bit(irq_enable_bit), .flag_write(flag_write),
    .flag_wdata(flag_wdata), .link_clk(link_clk), .byte_done_evt(byte_done_evt),
    .addr_match_evt(addr_match_evt), .arb_lost_evt(arb_lost_evt), .link_active(link_active),
    .irq_pending_flag(irq_pending_flag), .byte_done_status(byte_done_status),
    .addressed_as_target_status(addressed_as_target_status),
    .arbitration_lost_status(arbitration_lost_status), .irq_req(irq_req), .mcu_reset_req(mcu_reset_req));

  link_event_source u_link_event_source (.link_clk(link_clk), .byte_done_evt(byte_done_evt),
    .addr_match_evt(addr_match_evt), .arb_lost_evt(arb_lost_evt));

  // ----------------------------------------------------------------
  // compare, settle, flag write, verdict
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [4:0] exp, input logic [4:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s exp %h seen %h", name, exp, got);
    end
  endtask

  task automatic settle(input string name);
    repeat (24) @(negedge mclk);
    check("pending notes", 5'h00, 5'(exp_q.size()));
    check("reset_req", 5'h00, {4'h0, mcu_reset_req});
    $display("test %s done", name);
  endtask

  task automatic wr_flag(input logic d);
    @(negedge mclk);
    flag_write = 1'b1;
    flag_wdata = d;
    @(negedge mclk);
    flag_write = 1'b0;
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // output watcher: each change takes the oldest note
  // ----------------------------------------------------------------
  always @(negedge mclk) begin
    if (seen !== prev_q) begin
      if (exp_q.size() == 0)
        check("unexpected change", prev_q, seen);
      else
        check("irq outputs", exp_q.pop_front(), seen);
      prev_q <= seen;
    end
  end

  initial begin
    #50000;
    errors++;
    final_report();
  end

  initial begin
    int i;
    logic en;
    repeat (4) @(negedge mclk);
    resetn = 1'b1;
    check("link_active", 5'h00, {4'h0, link_active});
    u_link_event_source.send(EVT_BYTE_DONE);
    settle("disabled drop");
    two_wire_enable = 1'b1;
    for (i = 0; i < 30 && link_active !== 1'b1; i++) @(negedge mclk);
    check("link_active", 5'h01, {4'h0, link_active});
    for (i = 0; i < NUM_EVENTS; i++) begin
      en = 1'($random(seed));
      irq_enable_bit = en;
      exp_q.push_back({1'b1, 3'h4 >> i, en});
      u_link_event_source.send(i);
      settle("event");
      wr_flag(1'b0);
      settle("write zero");
      exp_q.push_back({1'b1, 3'h4 >> i, !en});
      irq_enable_bit = !en;
      settle("mask");
      exp_q.push_back(5'h00);
      wr_flag(1'b1);
      settle("clear");
    end
    irq_enable_bit = 1'b1;
    exp_q.push_back(5'h19);
    u_link_event_source.send(EVT_BYTE_DONE);
    settle("first of two");
    exp_q.push_back(5'h1b);
    u_link_event_source.send(EVT_ARB_LOST);
    settle("accumulate");
    exp_q.push_back(5'h00);
    resetn = 1'b0;
    repeat (4) @(negedge mclk);
    check("link_active", 5'h00, {4'h0, link_active});
    resetn = 1'b1;
    settle("mid-run reset");
    final_report();
  end
endmodule
